//--- rtl/vap_params.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: register index = byte address / 4 on classic wishbone
// Notes:   definitions only
`ifndef VAP_PARAMS_SVH
`define VAP_PARAMS_SVH
`define VAP_IDX_MCTL2       8'h0C
`define VAP_IDX_WAVSEL      8'h0D
`define VAP_IDX_NOLOAD      8'h0E
`define VAP_IDX_ACCUM       8'h0F
`define VAP_IDX_GAINCFG     8'h1B
`define VAP_IDX_IRQEN_LO    8'hD9
`define VAP_IDX_IRQEN_HI    8'hDB
`define VAP_IDX_IRQST_LO    8'hDC
`define VAP_IDX_VRMS        8'hE1
`define VAP_IDX_RMS_OS      8'hE2
`define VAP_IDX_PGAIN       8'hE3
`define VAP_IDX_POS         8'hE4
`define VAP_IDX_WAVE        8'hE5
`define VAP_IDX_APOWER      8'hE6
`define VAP_BIT_ZXUPD       0
`define VAP_BIT_SIGNDIR     0
`define VAP_BIT_SIGNPULSE   7
`define VAP_BIT_WAVEN       0
`define VAP_BIT_ST_NOLOAD   0
`define VAP_BIT_ST_SIGN     1
`define VAP_RST_BYTE        8'h00
`define VAP_RST_12          12'h000
`define VAP_RST_16          16'h0000
`define VAP_MCLK_HZ         25000000
`define VAP_UPDATE_DIV      5
`define VAP_VFILT_SHIFT     10
`define VAP_PFILT_SHIFT     10
`define VAP_PWR_FRAC_SHIFT  14
`define VAP_RMS_OS_WEIGHT   6
`define VAP_GAIN_SHIFT      12
`define VAP_OS_FRAC         8
`define VAP_NL_THR1         24'h00007E
`define VAP_NL_THR2         24'h00003F
`define VAP_NL_THR3         24'h00001F
`define VAP_SQRT_PER_CYC    6
`endif

//--- rtl/vap_pkg.sv
// Purpose: types shared by the voltage rms / active power path
// Assumes: constants live in vap_params.svh
// Notes:   types only
package vap_pkg;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [9:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} vap_wb_req_s;
	typedef struct packed {
		logic [23:0] volt;
		logic [23:0] curr;
	} vap_sample_s;
	typedef enum logic [2:0] {
		PH0 = 3'b000,
		PH1 = 3'b001,
		PH2 = 3'b010,
		PH3 = 3'b011,
		PH4 = 3'b100
	} vap_phase_e;
	typedef enum logic [1:0] {
		WAV_VOLT  = 2'b00,
		WAV_CURR  = 2'b01,
		WAV_POWER = 2'b10,
		WAV_VRMS  = 2'b11
	} vap_wav_e;
endpackage : vap_pkg

//--- rtl/vap_top.sv
// Purpose: voltage rms with offset trim and active power with gain,
//          offset, sign and no-load detection behind a wishbone slave
// Assumes: samples are signed 24-bit, steady across each 5-clock frame
// Notes:   one update every five clocks
//
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
`include "vap_params.svh"
module vap_top
	import vap_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	// wishbone slave
	input  wire vap_wb_req_s wb_req_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// converter samples and pulse output feedback
	input  wire vap_sample_s sample_i,
	input  wire logic        freq_pulse_i,
	// results
	output logic             irq_o,
	output logic             energy_accum_en_o
);
	vap_phase_e   phase_r;
	logic [7:0]   mctl2_r;
	logic [7:0]   wavsel_r;
	logic [7:0]   nlsel_r;
	logic [7:0]   accsel_r;
	logic [7:0]   gaincfg_r;
	logic [7:0]   irqen_lo_r;
	logic [7:0]   irqen_hi_r;
	logic [7:0]   irqst_r;
	logic [11:0]  rms_os_r;
	logic [11:0]  pgain_r;
	logic [15:0]  pos_r;
	logic [23:0]  vrms_r;
	logic [23:0]  wave_r;
	logic [23:0]  apower_r;
	logic [47:0]  ms_r;
	logic [47:0]  rad_r;
	logic [25:0]  rem_r;
	logic [23:0]  root_r;
	logic [47:0]  rad_nxt;
	logic [25:0]  rem_nxt;
	logic [23:0]  root_nxt;
	logic signed [47:0] pacc_r;
	logic         zx_pend_r;
	logic         vsign_r;
	logic         psign_r;
	logic         sign_evt;
	logic         nl_evt;
	logic         tick;
	logic         wb_hit;
	logic [7:0]   idx;
	logic [7:0]   clr_w1c;
	logic [23:0]  thr;
	logic [23:0]  apower_nxt;
	logic [23:0]  vrms_nxt;

	assign tick = (phase_r == PH0);
	assign wb_hit = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
	assign idx = wb_req_i.adr[9:2];

	// five-clock update frame
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			phase_r <= PH0;
		else
		begin
			case (phase_r)
				PH0: phase_r <= PH1;
				PH1: phase_r <= PH2;
				PH2: phase_r <= PH3;
				PH3: phase_r <= PH4;
				default: phase_r <= PH0;
			endcase
		end
	end

	// wishbone: ack one clock after the request, dropped the clock after
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= wb_hit;
			if (wb_hit && !wb_req_i.we)
			begin
				case (idx)
					`VAP_IDX_MCTL2:    wb_dat_o <= {24'h000000, mctl2_r};
					`VAP_IDX_WAVSEL:   wb_dat_o <= {24'h000000, wavsel_r};
					`VAP_IDX_NOLOAD:   wb_dat_o <= {24'h000000, nlsel_r};
					`VAP_IDX_ACCUM:    wb_dat_o <= {24'h000000, accsel_r};
					`VAP_IDX_GAINCFG:  wb_dat_o <= {24'h000000, gaincfg_r};
					`VAP_IDX_IRQEN_LO: wb_dat_o <= {24'h000000, irqen_lo_r};
					`VAP_IDX_IRQEN_HI: wb_dat_o <= {24'h000000, irqen_hi_r};
					`VAP_IDX_IRQST_LO: wb_dat_o <= {24'h000000, irqst_r};
					`VAP_IDX_VRMS:     wb_dat_o <= {8'h00, vrms_r};
					`VAP_IDX_RMS_OS:   wb_dat_o <= {20'h00000, rms_os_r};
					`VAP_IDX_PGAIN:    wb_dat_o <= {20'h00000, pgain_r};
					`VAP_IDX_POS:      wb_dat_o <= {16'h0000, pos_r};
					`VAP_IDX_WAVE:     wb_dat_o <= {8'h00, wave_r};
					`VAP_IDX_APOWER:   wb_dat_o <= {8'h00, apower_r};
					default:           wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	// software-written configuration, byte lanes honoured
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mctl2_r    <= `VAP_RST_BYTE;
			wavsel_r   <= `VAP_RST_BYTE;
			nlsel_r    <= `VAP_RST_BYTE;
			accsel_r   <= `VAP_RST_BYTE;
			gaincfg_r  <= `VAP_RST_BYTE;
			irqen_lo_r <= `VAP_RST_BYTE;
			irqen_hi_r <= `VAP_RST_BYTE;
			rms_os_r   <= `VAP_RST_12;
			pgain_r    <= `VAP_RST_12;
			pos_r      <= `VAP_RST_16;
		end
		else if (wb_hit && wb_req_i.we)
		begin
			if (wb_req_i.sel[0])
			begin
				case (idx)
					`VAP_IDX_MCTL2:    mctl2_r    <= wb_req_i.dat[7:0];
					`VAP_IDX_WAVSEL:   wavsel_r   <= wb_req_i.dat[7:0];
					`VAP_IDX_NOLOAD:   nlsel_r    <= wb_req_i.dat[7:0];
					`VAP_IDX_ACCUM:    accsel_r   <= wb_req_i.dat[7:0];
					`VAP_IDX_GAINCFG:  gaincfg_r  <= wb_req_i.dat[7:0];
					`VAP_IDX_IRQEN_LO: irqen_lo_r <= wb_req_i.dat[7:0];
					`VAP_IDX_IRQEN_HI: irqen_hi_r <= wb_req_i.dat[7:0];
					`VAP_IDX_RMS_OS:   rms_os_r[7:0] <= wb_req_i.dat[7:0];
					`VAP_IDX_PGAIN:    pgain_r[7:0]  <= wb_req_i.dat[7:0];
					`VAP_IDX_POS:      pos_r[7:0]    <= wb_req_i.dat[7:0];
					default: ;
				endcase
			end
			if (wb_req_i.sel[1])
			begin
				case (idx)
					`VAP_IDX_RMS_OS: rms_os_r[11:8] <= wb_req_i.dat[11:8];
					`VAP_IDX_PGAIN:  pgain_r[11:8]  <= wb_req_i.dat[11:8];
					`VAP_IDX_POS:    pos_r[15:8]    <= wb_req_i.dat[15:8];
					default: ;
				endcase
			end
		end
	end

	// mean square of voltage, first-order low-pass
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			ms_r <= 48'h000000000000;
		else if (tick)
		begin : ms_upd
			logic signed [47:0] sq;
			logic signed [49:0] diff;
			sq = $signed(sample_i.volt) * $signed(sample_i.volt);
			diff = $signed({2'b00, sq}) - $signed({2'b00, ms_r});
			ms_r <= ms_r + 48'(diff >>> `VAP_VFILT_SHIFT);
		end
	end

	// square root, six bits a clock over PH1..PH4
	always_comb
	begin
		rad_nxt = rad_r;
		rem_nxt = rem_r;
		root_nxt = root_r;
		for (int k = 0; k < `VAP_SQRT_PER_CYC; k++)
		begin
			rem_nxt = {rem_nxt[23:0], rad_nxt[47:46]};
			rad_nxt = {rad_nxt[45:0], 2'b00};
			if (rem_nxt >= {root_nxt, 2'b01})
			begin
				rem_nxt = rem_nxt - {root_nxt, 2'b01};
				root_nxt = {root_nxt[22:0], 1'b1};
			end
			else
				root_nxt = {root_nxt[22:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rad_r  <= 48'h000000000000;
			rem_r  <= 26'h0000000;
			root_r <= 24'h000000;
		end
		else if (tick)
		begin
			rad_r  <= ms_r;
			rem_r  <= 26'h0000000;
			root_r <= 24'h000000;
		end
		else
		begin
			rad_r  <= rad_nxt;
			rem_r  <= rem_nxt;
			root_r <= root_nxt;
		end
	end

	// offset correction, clamped at zero and at full scale
	always_comb
	begin : vrms_corr
		logic signed [26:0] sum;
		sum = $signed({3'b000, root_r})
			+ ($signed({{15{rms_os_r[11]}}, rms_os_r})
			<<< `VAP_RMS_OS_WEIGHT);
		if (sum < 0)
			vrms_nxt = 24'h000000;
		else if (sum > $signed(27'h0FFFFFF))
			vrms_nxt = 24'hFFFFFF;
		else
			vrms_nxt = sum[23:0];
	end

	// voltage zero crossing seen since the last gated update
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			vsign_r   <= 1'b0;
			zx_pend_r <= 1'b0;
		end
		else if (tick)
		begin
			vsign_r <= sample_i.volt[23];
			if (vsign_r != sample_i.volt[23])
				zx_pend_r <= 1'b1;
			else if (mctl2_r[`VAP_BIT_ZXUPD])
				zx_pend_r <= 1'b0;
		end
	end

	// root finished at PH4 is committed at the next frame start; with ZXUPD set, only while a crossing is pending
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			vrms_r <= 24'h000000;
		else if (tick)
		begin
			if (!mctl2_r[`VAP_BIT_ZXUPD])
				vrms_r <= vrms_nxt;
			else if (zx_pend_r)
				vrms_r <= vrms_nxt;
		end
	end

	// instantaneous power into the power low-pass stage
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			pacc_r <= 48'sh000000000000;
		else if (tick)
		begin : pw_upd
			logic signed [47:0] prod;
			logic signed [48:0] diff;
			prod = $signed(sample_i.volt) * $signed(sample_i.curr);
			diff = 49'(prod) - 49'(pacc_r);
			pacc_r <= pacc_r + 48'(diff >>> `VAP_PFILT_SHIFT);
		end
	end

	// offset (8 fraction bits), gain, then back to sample LSBs
	always_comb
	begin : pw_trim
		logic signed [39:0] pf;
		logic signed [39:0] g;
		logic signed [51:0] scl;
		logic signed [39:0] w;
		pf = 40'(pacc_r >>> `VAP_PWR_FRAC_SHIFT);
		pf = pf + 40'($signed(pos_r));
		scl = 52'(pf) * 52'($signed(pgain_r));
		g = pf + 40'(scl >>> `VAP_GAIN_SHIFT);
		w = g >>> `VAP_OS_FRAC;
		if (w > $signed(40'sh00007FFFFF))
			apower_nxt = 24'h7FFFFF;
		else if (w < $signed(-40'sh0000800000))
			apower_nxt = 24'h800000;
		else
			apower_nxt = w[23:0];
	end

	always_comb
	begin
		case (nlsel_r[1:0])
			2'b01:   thr = `VAP_NL_THR1;
			2'b10:   thr = `VAP_NL_THR2;
			2'b11:   thr = `VAP_NL_THR3;
			default: thr = 24'h000000;
		endcase
	end

	// power register, no-load and sign tracking, once per frame
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			apower_r <= 24'h000000;
			psign_r  <= 1'b0;
			nl_evt   <= 1'b0;
			sign_evt <= 1'b0;
			energy_accum_en_o <= 1'b0;
		end
		else
		begin
			nl_evt   <= 1'b0;
			sign_evt <= 1'b0;
			if (phase_r == PH1)
			begin : pw_stage
				logic [23:0] mag;
				logic        b;
				logic        smp;
				apower_r <= apower_nxt;
				mag = apower_nxt[23] ? (~apower_nxt + 24'h000001) : apower_nxt;
				b = (nlsel_r[1:0] != 2'b00) && (mag < thr);
				nl_evt <= b;
				energy_accum_en_o <= ~b;
				// per-pulse mode samples the sign only on an output pulse
				smp = gaincfg_r[`VAP_BIT_SIGNPULSE] ? freq_pulse_i : 1'b1;
				if (smp)
				begin
					psign_r <= apower_nxt[23];
					if (!accsel_r[`VAP_BIT_SIGNDIR])
						sign_evt <= ~psign_r & apower_nxt[23];
					else
						sign_evt <= psign_r & ~apower_nxt[23];
				end
			end
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	always_comb
	begin
		clr_w1c = 8'h00;
		if (wb_hit && wb_req_i.we && wb_req_i.sel[0]
			&& idx == `VAP_IDX_IRQST_LO)
			clr_w1c = wb_req_i.dat[7:0];
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			irqst_r <= 8'h00;
		else
		begin
			irqst_r <= irqst_r & ~clr_w1c;
			if (sign_evt)
				irqst_r[`VAP_BIT_ST_SIGN] <= 1'b1;
			else if (clr_w1c[`VAP_BIT_ST_SIGN])
				irqst_r[`VAP_BIT_ST_SIGN] <= 1'b0;
			if (nl_evt)
				irqst_r[`VAP_BIT_ST_NOLOAD] <= 1'b1;
			else if (clr_w1c[`VAP_BIT_ST_NOLOAD])
				irqst_r[`VAP_BIT_ST_NOLOAD] <= 1'b0;
		end
	end

	// level interrupt, one clock behind status
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irqst_r & irqen_lo_r);
	end

	// waveform register, captured at each frame start while enabled
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			wave_r <= 24'h000000;
		else if (tick && irqen_hi_r[`VAP_BIT_WAVEN])
		begin
			case (vap_wav_e'(wavsel_r[1:0]))
				WAV_VOLT:  wave_r <= sample_i.volt;
				WAV_CURR:  wave_r <= sample_i.curr;
				WAV_POWER: wave_r <= apower_r;
				WAV_VRMS:  wave_r <= vrms_r;
				default:   wave_r <= 24'h000000;
			endcase
		end
	end
endmodule : vap_top

//--- sim/tb.sv
// Purpose: register-level tests of vap_top
// Assumes: zero current keeps filtered power at zero
// Notes:   trims then give exact results
`timescale 1ns/10ps
`include "vap_params.svh"
module tb;
	import vap_pkg::*;
	logic        clk_sys_i;
	logic        reset_n_i;
	vap_wb_req_s wb_req_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	vap_sample_s sample_i;
	logic        freq_pulse_i;
	logic        irq_o;
	logic        energy_accum_en_o;
	logic [23:0] volt_set;
	logic [23:0] curr_set;
	logic        pulse_set;
	logic [31:0] d;
	int          errors;
	int          check_count;
	int          m;
	logic [7:0]  ra [12] = '{`VAP_IDX_MCTL2, `VAP_IDX_WAVSEL,
		`VAP_IDX_NOLOAD, `VAP_IDX_ACCUM, `VAP_IDX_GAINCFG,
		`VAP_IDX_IRQEN_LO, `VAP_IDX_IRQEN_HI, `VAP_IDX_IRQST_LO,
		`VAP_IDX_VRMS, `VAP_IDX_RMS_OS, `VAP_IDX_PGAIN, `VAP_IDX_POS};
	logic [7:0]  wa [4] = '{8'h00, `VAP_IDX_GAINCFG, `VAP_IDX_PGAIN,
		`VAP_IDX_POS};
	logic [31:0] wm [4] = '{32'h0, 32'hFF, 32'hFFF, 32'hFFFF};
	vap_top u_vap_top (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.sample_i(sample_i), .freq_pulse_i(freq_pulse_i), .irq_o(irq_o),
		.energy_accum_en_o(energy_accum_en_o));
	vap_adc_model u_vap_adc_model (.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i), .volt_set_i(volt_set),
		.curr_set_i(curr_set),
		.pulse_set_i(pulse_set), .sample_o(sample_i),
		.freq_pulse_o(freq_pulse_i));
	initial
	begin
		clk_sys_i = 1'h0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	task end_sim;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int n;
		wb_req_i <= '{1'h1, 1'h1, w, {a, 2'h0}, 4'hF, v};
		n = 0;
		do
		begin
			@(posedge clk_sys_i);
			n++;
		end
		while (wb_ack_o !== 1'h1 && n < 50);
		if (n >= 50)
		begin
			errors++;
			end_sim;
		end
		d = wb_dat_o;
		wb_req_i.cyc <= 1'h0;
		wb_req_i.stb <= 1'h0;
		@(posedge clk_sys_i);
	endtask : wb
	task wr(input logic [7:0] a, input logic [31:0] v);
		wb(1'h1, a, v);
	endtask : wr
	task rc(input string n, input logic [7:0] a, input logic [31:0] e);
		wb(1'h0, a, 32'h0);
		cmp(n, e, d);
	endtask : rc
	// frames are five clocks; fifteen covers the result lag
	task wt(input int c);
		repeat (c) @(posedge clk_sys_i);
	endtask : wt
	initial
	begin
		repeat (8000) @(posedge clk_sys_i);
		errors++;
		end_sim;
	end
	initial
	begin
		errors = 0;
		check_count = 0;
		reset_n_i = 1'h0;
		wb_req_i = '0;
		volt_set = 24'h000000;
		curr_set = 24'h000000;
		pulse_set = 1'h0;
		repeat (16) @(posedge clk_sys_i);
		reset_n_i <= 1'h1;
		@(posedge clk_sys_i);
		foreach (ra[i])
			rc("reset", ra[i], 32'h0);
		foreach (wa[i])
		begin
			wr(wa[i], 32'hFFFFFFFF);
			rc("width", wa[i], wm[i]);
			wr(wa[i], 32'h0);
		end
		wr(`VAP_IDX_RMS_OS, 32'h2);
		wt(15);
		rc("vrms_os", `VAP_IDX_VRMS, 32'h80);
		wr(`VAP_IDX_RMS_OS, 32'hFFE);
		wt(15);
		rc("vrms_clamp", `VAP_IDX_VRMS, 32'h0);
		wr(`VAP_IDX_RMS_OS, 32'h3);
		wt(15);
		wr(`VAP_IDX_MCTL2, 32'h1);
		wr(`VAP_IDX_RMS_OS, 32'h5);
		wt(15);
		rc("vrms_held", `VAP_IDX_VRMS, 32'hC0);
		volt_set <= 24'h000001;
		wt(15);
		volt_set <= 24'hFFFFFF;
		wt(15);
		wb(1'h0, `VAP_IDX_VRMS, 32'h0);
		cmp("vrms_zx", 32'h1, {31'h0, d >= 32'h140 && d < 32'h148});
		wr(`VAP_IDX_MCTL2, 32'h0);
		volt_set <= 24'h000000;
		wr(`VAP_IDX_POS, 32'h1000);
		wt(15);
		rc("pwr_os", `VAP_IDX_APOWER, 32'h10);
		wr(`VAP_IDX_PGAIN, 32'h800);
		wt(15);
		rc("pwr_gmin", `VAP_IDX_APOWER, 32'h8);
		wr(`VAP_IDX_PGAIN, 32'h7FF);
		wt(15);
		wb(1'h0, `VAP_IDX_APOWER, 32'h0);
		cmp("pwr_gmax", 32'h1, {31'h0, d == 32'h17 || d == 32'h18});
		wr(`VAP_IDX_PGAIN, 32'h0);
		wr(`VAP_IDX_IRQEN_LO, 32'h2);
		wr(`VAP_IDX_IRQST_LO, 32'hFF);
		wr(`VAP_IDX_POS, 32'hF000);
		wt(15);
		rc("sign_pn", `VAP_IDX_IRQST_LO, 32'h2);
		cmp("irq_on", 32'h1, {31'h0, irq_o});
		wr(`VAP_IDX_IRQEN_LO, 32'h0);
		wt(3);
		cmp("irq_mask", 32'h0, {31'h0, irq_o});
		wr(`VAP_IDX_IRQST_LO, 32'h2);
		rc("sign_clr", `VAP_IDX_IRQST_LO, 32'h0);
		wr(`VAP_IDX_ACCUM, 32'h1);
		wr(`VAP_IDX_POS, 32'h1000);
		wt(15);
		rc("sign_np", `VAP_IDX_IRQST_LO, 32'h2);
		wr(`VAP_IDX_IRQST_LO, 32'h2);
		wr(`VAP_IDX_POS, 32'hF000);
		wt(15);
		rc("sign_pn_off", `VAP_IDX_IRQST_LO, 32'h0);
		wr(`VAP_IDX_ACCUM, 32'h0);
		wr(`VAP_IDX_GAINCFG, 32'h80);
		wr(`VAP_IDX_POS, 32'h1000);
		pulse_set <= 1'h1;
		wt(10);
		pulse_set <= 1'h0;
		wt(10);
		wr(`VAP_IDX_IRQST_LO, 32'h2);
		wr(`VAP_IDX_POS, 32'hF000);
		wt(15);
		rc("sign_nopulse", `VAP_IDX_IRQST_LO, 32'h0);
		pulse_set <= 1'h1;
		wt(10);
		pulse_set <= 1'h0;
		wt(10);
		rc("sign_pulse", `VAP_IDX_IRQST_LO, 32'h2);
		wr(`VAP_IDX_GAINCFG, 32'h0);
		wr(`VAP_IDX_POS, 32'h4000);
		wr(`VAP_IDX_IRQEN_LO, 32'h1);
		for (m = 0; m < 4; m++)
		begin
			wr(`VAP_IDX_NOLOAD, m);
			wt(15);
			wr(`VAP_IDX_IRQST_LO, 32'hFF);
			wt(15);
			cmp("accum", m != 1, energy_accum_en_o);
			rc("noload", `VAP_IDX_IRQST_LO, m == 1);
			cmp("irq_nl", m == 1, irq_o);
		end
		wr(`VAP_IDX_WAVSEL, 32'h2);
		wr(`VAP_IDX_IRQEN_HI, 32'h1);
		wt(15);
		rc("wave_pwr", `VAP_IDX_WAVE, 32'h40);
		wr(`VAP_IDX_RMS_OS, 32'h0);
		volt_set <= 24'h100000;
		curr_set <= 24'hF00000;
		wt(20);
		wb(1'h0, `VAP_IDX_VRMS, 32'h0);
		cmp("vrms_on", 32'h1, {31'h0, d > 32'h0 && d <= 32'h100000});
		wb(1'h0, `VAP_IDX_APOWER, 32'h0);
		cmp("pwr_prod", 32'h1, {31'h0, d[23]});
		end_sim;
	end
endmodule : tb

//--- sim/vap_adc_model.sv
// Purpose: converter front end and pulse output stand-in
// Assumes: bench changes set values rarely
// Notes:   current follows the bench; zero leaves power to the trims
`timescale 1ns/10ps
module vap_adc_model
	import vap_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	// values asked for by the bench
	input  wire logic [23:0] volt_set_i,
	input  wire logic [23:0] curr_set_i,
	input  wire logic        pulse_set_i,
	// toward the block
	output vap_sample_s      sample_o,
	output logic             freq_pulse_o
);
	// registered so samples only move just after an edge
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
		if (!reset_n_i)
		begin
			sample_o     <= '0;
			freq_pulse_o <= 1'h0;
		end
		else
		begin
			sample_o.volt <= volt_set_i;
			sample_o.curr <= curr_set_i;
			freq_pulse_o  <= pulse_set_i;
		end
endmodule : vap_adc_model

//--- sim/vap_top_sva.sv
// Purpose: port checker for vap_top
// Assumes: wishbone answer one cycle after take
// Notes:   bound at the foot of this file
`timescale 1ns/10ps
`include "vap_params.svh"
module vap_top_sva
	import vap_pkg::*;
(
	// watched ports
	input wire logic        clk_sys_i,
	input wire logic        reset_n_i,
	input wire vap_wb_req_s wb_req_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        irq_o,
	input wire logic        energy_accum_en_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);
	wire [7:0] idx = wb_req_i.adr[9:2];
	wire       req = wb_req_i.cyc && wb_req_i.stb;
	wire       rd  = req && !wb_ack_o && !wb_req_i.we;
	// mask writes also drop irq, so both count as a cause
	wire       wclr = req && wb_req_i.we &&
		(idx == `VAP_IDX_IRQST_LO || idx == `VAP_IDX_IRQEN_LO);
	sequence s_take;
		req && !wb_ack_o;
	endsequence
	AST_ACK_NEXT: assert property (s_take |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(req))
		else $error("ack without request");
	AST_UNMAP: assert property (rd && idx == 8'h00 |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	AST_BYTE_W: assert property (rd && idx inside {`VAP_IDX_MCTL2,
		`VAP_IDX_NOLOAD, `VAP_IDX_ACCUM, `VAP_IDX_GAINCFG,
		`VAP_IDX_IRQEN_LO, `VAP_IDX_IRQST_LO} |=> wb_dat_o[31:8] == 24'h0)
		else $error("byte register upper bits set");
	AST_VRMS_W: assert property
		(rd && idx == `VAP_IDX_VRMS |=> wb_dat_o[31:24] == 8'h0)
		else $error("rms wider than 24 bits");
	AST_TRIM_W: assert property
		(rd && idx inside {`VAP_IDX_RMS_OS, `VAP_IDX_PGAIN}
		|=> wb_dat_o[31:12] == 20'h0)
		else $error("12-bit trim upper bits set");
	AST_POS_W: assert property
		(rd && idx == `VAP_IDX_POS |=> wb_dat_o[31:16] == 16'h0)
		else $error("power offset upper bits set");
	AST_IRQ_CLR: assert property
		($fell(irq_o) |-> $past(wclr) || $past(wclr, 2) || $past(wclr, 3))
		else $error("irq dropped without clear or mask");
	AST_ACC_HOLD: assert property
		($changed(energy_accum_en_o) |=> $stable(energy_accum_en_o)[*4])
		else $error("accumulate enable moved inside a frame");
endmodule : vap_top_sva
bind vap_top vap_top_sva u_vap_top_sva (.clk_sys_i(clk_sys_i),
	.reset_n_i(reset_n_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .irq_o(irq_o),
	.energy_accum_en_o(energy_accum_en_o));
